/* logic/rtwt_map.vh */
// Register indices, field positions and reset values of the timer block
`ifndef RTWT_MAP_VH
`define RTWT_MAP_VH
// Register indices (byte address is four times the index)
`define RTWT_IDX_T3_CONTROL 8'h1e
`define RTWT_IDX_T3_RELOAD_UPPER 8'h1f
`define RTWT_IDX_T3_RELOAD_LOWER 8'h20
`define RTWT_IDX_T3_COUNT_UPPER 8'h21
`define RTWT_IDX_T3_COUNT_LOWER 8'h22
`define RTWT_IDX_WAKEUP_CONTROL 8'h23
`define RTWT_IDX_WAKEUP_RELOAD 8'h30
`define RTWT_IDX_T3_COMMAND 8'h31
// Third timer control fields
`define RTWT_T3_HALT_RX_BIT 7
`define RTWT_T3_START_HI 5
`define RTWT_T3_START_LO 4
`define RTWT_T3_AUTO_BIT 3
`define RTWT_T3_CLK_HI 1
`define RTWT_T3_CLK_LO 0
`define RTWT_T3_CONTROL_MASK 8'hbb
// Clock select codes
`define RTWT_CLK_SYSTEM 2'h0
`define RTWT_CLK_DERIVED 2'h1
`define RTWT_CLK_FIRST_UF 2'h2
`define RTWT_CLK_SECOND_UF 2'h3
// Start mode codes
`define RTWT_START_NONE 2'h0
`define RTWT_START_TX_END 2'h1
`define RTWT_START_TRIM 2'h2
`define RTWT_START_TRIM_UF 2'h3
// Wake-up control fields
`define RTWT_WU_ACTIVE_BIT 7
`define RTWT_WU_GATE_BIT 6
`define RTWT_WU_TRIM_BIT 5
`define RTWT_WU_CARD_BIT 4
`define RTWT_WU_AUTO_BIT 3
`define RTWT_WU_WAKE_BIT 2
`define RTWT_WU_CLK_HI 1
`define RTWT_WU_CLK_LO 0
// Command and status fields
`define RTWT_CMD_FLAG_BIT 0
`define RTWT_CMD_START_BIT 1
`define RTWT_CMD_STOP_BIT 2
`define RTWT_CMD_RUN_BIT 3
// Wake-up prescaler divide values minus one
`define RTWT_DIV1 5'h00
`define RTWT_DIV8 5'h07
`define RTWT_DIV16 5'h0f
`define RTWT_DIV32 5'h1f
// Reset values
`define RTWT_RST_BYTE 8'h00
`define RTWT_RST_WORD 16'h0000
`endif

/* logic/rtwt_timer.v */
// Third general timer and wake-up timer with an AHB-Lite register slave
// Behaviour
// - Clock select 00 counts on the system clock and 01 on the derived 211,875 kHz clock.
// - Clock select 10 counts on first timer underflows and 11 on second timer underflows.
// - The reload value is held in a writable upper byte and lower byte register.
// - Every start event copies the full reload value into the counter before counting.
// - Writing a reload byte leaves a running count alone until the next start event or the next auto reload at zero.
// - The live count reads back as a read-only upper byte and lower byte.
// - With wake-up enabled, expiry of the wake-up timer brings the system active.
// - With card detection enabled, expiry launches low-power card detection by itself.
// - Bit 7 of the wake-up control register reads whether the wake-up timer runs.
// - A control write with bit 6 set loads bit 7 into the running flag.
// - Bit 6 is write-only and a write with it clear leaves the running flag alone.
// - The start mode picks no auto start, start at transmit end, or trimming with or without underflow.
// - With auto reload the timer reloads at zero, otherwise stops, and each underflow sets the flag, except in trimming without underflow, which only stops.
// - Halt on receive stops the timer after the first four received bits, except in trimming modes.
// - The wake-up clock is the low-frequency oscillator divided by 1, 8, 16 or 32.
`timescale 1ns/1ps
`include "rtwt_map.vh"
module rtwt_timer (
   input wire i_clk,
   input wire i_rst,
   input wire i_hsel,
   input wire [31:0] i_haddr,
   input wire [1:0] i_htrans,
   input wire i_hwrite,
   input wire [2:0] i_hsize,
   input wire [31:0] i_hwdata,
   input wire i_hready,
   output reg [31:0] o_hrdata,
   output wire o_hreadyout,
   output wire o_hresp,
   input wire i_derived_tick,
   input wire i_first_underflow,
   input wire i_second_underflow,
   input wire i_tx_end,
   input wire i_rx_four_bits,
   input wire i_lfo_clk,
   output reg o_timer3_underflow,
   output wire o_timer3_running,
   output reg o_wakeup,
   output reg o_card_detect_start,
   output reg o_trim_start
);

   // ****************************************
   // Helper functions
   // ****************************************
   function [4:0] rtwt_div_limit;
      input [1:0] sel;
      begin
         case (sel)
            2'h0: rtwt_div_limit = `RTWT_DIV1;
            2'h1: rtwt_div_limit = `RTWT_DIV8;
            2'h2: rtwt_div_limit = `RTWT_DIV16;
            default: rtwt_div_limit = `RTWT_DIV32;
         endcase
      end
   endfunction

   function rtwt_is_trim;
      input [1:0] mode;
      begin
         rtwt_is_trim = (mode == `RTWT_START_TRIM) || (mode == `RTWT_START_TRIM_UF);
      end
   endfunction

   // ****************************************
   // Register storage
   // ****************************************
   reg [7:0] t3_control;
   reg [7:0] third_timer_reload_upper;
   reg [7:0] third_timer_reload_lower;
   reg [15:0] t3_count;
   reg t3_running;
   reg underflow_flag;
   reg [5:0] wakeup_timer_control;
   reg wakeup_timer_active_flag;
   reg [15:0] wakeup_reload;
   reg [15:0] wakeup_count;
   reg [4:0] wakeup_prescale;

   wire [1:0] third_timer_clock_select = t3_control[`RTWT_T3_CLK_HI:`RTWT_T3_CLK_LO];
   wire [1:0] third_timer_start_mode = t3_control[`RTWT_T3_START_HI:`RTWT_T3_START_LO];
   wire third_timer_auto_reload = t3_control[`RTWT_T3_AUTO_BIT];
   wire third_timer_halt_on_receive = t3_control[`RTWT_T3_HALT_RX_BIT];
   wire wakeup_auto_oscillator_trim = wakeup_timer_control[`RTWT_WU_TRIM_BIT];
   wire wakeup_auto_card_detect = wakeup_timer_control[`RTWT_WU_CARD_BIT];
   wire wakeup_auto_reload = wakeup_timer_control[`RTWT_WU_AUTO_BIT];
   wire wakeup_on_expiry_enable = wakeup_timer_control[`RTWT_WU_WAKE_BIT];
   wire [1:0] wakeup_clock_select = wakeup_timer_control[`RTWT_WU_CLK_HI:`RTWT_WU_CLK_LO];

   // ****************************************
   // AHB-Lite slave
   // ****************************************
   reg wr_pending;
   reg [7:0] wr_index;
   wire bus_take = i_hsel && i_hready && i_htrans[1];
   wire [7:0] bus_index = i_haddr[9:2];
   wire in_range = (i_haddr[31:10] == 22'h00_0000);
   wire wr_en = wr_pending;
   wire [7:0] wr_byte = i_hwdata[7:0];
   reg [7:0] next_rdata;

   assign o_hreadyout = 1'b1;
   assign o_hresp = 1'b0;

   always @(posedge i_clk) begin
      if (i_rst) begin
         wr_pending <= 1'b0;
         wr_index <= `RTWT_RST_BYTE;
      end else begin
         wr_pending <= bus_take && i_hwrite && in_range;
         wr_index <= bus_index;
      end
   end

   always @* begin
      next_rdata = `RTWT_RST_BYTE;
      if (in_range) begin
         case (bus_index)
            `RTWT_IDX_T3_CONTROL: next_rdata = t3_control;
            `RTWT_IDX_T3_RELOAD_UPPER: next_rdata = third_timer_reload_upper;
            `RTWT_IDX_T3_RELOAD_LOWER: next_rdata = third_timer_reload_lower;
            `RTWT_IDX_T3_COUNT_UPPER: next_rdata = t3_count[15:8];
            `RTWT_IDX_T3_COUNT_LOWER: next_rdata = t3_count[7:0];
            `RTWT_IDX_WAKEUP_CONTROL: begin
               next_rdata = {wakeup_timer_active_flag, 1'b0, wakeup_timer_control};
            end
            `RTWT_IDX_T3_COMMAND: next_rdata = {4'h0, t3_running, 2'h0, underflow_flag};
            default: next_rdata = `RTWT_RST_BYTE;
         endcase
      end
   end

   always @(posedge i_clk) begin
      if (i_rst) begin
         o_hrdata <= 32'h0000_0000;
      end else if (bus_take && !i_hwrite) begin
         if (in_range && bus_index == `RTWT_IDX_WAKEUP_RELOAD) begin
            o_hrdata <= {16'h0000, wakeup_reload};
         end else begin
            o_hrdata <= {24'h00_0000, next_rdata};
         end
      end
   end

   // ****************************************
   // Low-frequency oscillator synchroniser
   // ****************************************
   reg lfo_s1;
   reg lfo_s2;
   reg lfo_s3;
   reg lfo_level;
   wire lfo_agree = (lfo_s2 == lfo_s3);
   wire lfo_rise = lfo_agree && lfo_s3 && !lfo_level;

   always @(posedge i_clk) begin
      if (i_rst) begin
         lfo_s1 <= 1'b0;
         lfo_s2 <= 1'b0;
         lfo_s3 <= 1'b0;
         lfo_level <= 1'b0;
      end else begin
         lfo_s1 <= i_lfo_clk;
         lfo_s2 <= lfo_s1;
         lfo_s3 <= lfo_s2;
         if (lfo_agree) begin
            lfo_level <= lfo_s3;
         end
      end
   end

   // ****************************************
   // Third timer
   // ****************************************
   reg t3_tick;
   wire trim_mode = rtwt_is_trim(third_timer_start_mode);
   wire wr_cmd = wr_en && (wr_index == `RTWT_IDX_T3_COMMAND);
   wire cmd_start = wr_cmd && wr_byte[`RTWT_CMD_START_BIT];
   wire cmd_stop = wr_cmd && wr_byte[`RTWT_CMD_STOP_BIT];
   wire flag_clear = wr_cmd && wr_byte[`RTWT_CMD_FLAG_BIT];
   wire trim_edge = trim_mode && lfo_rise;
   wire auto_start = (third_timer_start_mode == `RTWT_START_TX_END) && i_tx_end;
   wire start_event = cmd_start || auto_start || (trim_edge && !t3_running);
   wire trim_stop = trim_edge && t3_running;
   wire rx_halt = third_timer_halt_on_receive && !trim_mode && i_rx_four_bits;
   wire t3_at_zero = (t3_count == `RTWT_RST_WORD);
   wire t3_step = t3_running && t3_tick && !start_event;
   wire t3_uf = t3_step && t3_at_zero;
   wire uf_allowed = (third_timer_start_mode != `RTWT_START_TRIM);

   assign o_timer3_running = t3_running;

   always @* begin
      case (third_timer_clock_select)
         `RTWT_CLK_SYSTEM: t3_tick = 1'b1;
         `RTWT_CLK_DERIVED: t3_tick = i_derived_tick;
         `RTWT_CLK_FIRST_UF: t3_tick = i_first_underflow;
         `RTWT_CLK_SECOND_UF: t3_tick = i_second_underflow;
         default: t3_tick = 1'b0;
      endcase
   end

   always @(posedge i_clk) begin
      if (i_rst) begin
         t3_control <= `RTWT_RST_BYTE;
         third_timer_reload_upper <= `RTWT_RST_BYTE;
         third_timer_reload_lower <= `RTWT_RST_BYTE;
      end else if (wr_en) begin
         case (wr_index)
            `RTWT_IDX_T3_CONTROL: t3_control <= wr_byte & `RTWT_T3_CONTROL_MASK;
            `RTWT_IDX_T3_RELOAD_UPPER: third_timer_reload_upper <= wr_byte;
            `RTWT_IDX_T3_RELOAD_LOWER: third_timer_reload_lower <= wr_byte;
            default: t3_control <= t3_control;
         endcase
      end
   end

   always @(posedge i_clk) begin
      if (i_rst) begin
         t3_count <= `RTWT_RST_WORD;
         t3_running <= 1'b0;
         underflow_flag <= 1'b0;
         o_timer3_underflow <= 1'b0;
      end else begin
         o_timer3_underflow <= t3_uf && uf_allowed;
         if (t3_uf && uf_allowed) begin
            underflow_flag <= 1'b1;
         end else if (flag_clear) begin
            underflow_flag <= 1'b0;
         end
         if (start_event) begin
            t3_count <= {third_timer_reload_upper, third_timer_reload_lower};
            t3_running <= 1'b1;
         end else if (cmd_stop || trim_stop || rx_halt) begin
            t3_running <= 1'b0;
         end else if (t3_uf) begin
            if (third_timer_auto_reload && uf_allowed) begin
               t3_count <= {third_timer_reload_upper, third_timer_reload_lower};
            end else begin
               t3_running <= 1'b0;
            end
         end else if (t3_step) begin
            t3_count <= t3_count - 16'h0001;
         end
      end
   end

   // ****************************************
   // Wake-up timer
   // ****************************************
   wire wr_wu = wr_en && (wr_index == `RTWT_IDX_WAKEUP_CONTROL);
   wire wu_gate = wr_wu && wr_byte[`RTWT_WU_GATE_BIT];
   wire wu_begin = wu_gate && wr_byte[`RTWT_WU_ACTIVE_BIT] && !wakeup_timer_active_flag;
   wire wu_tick = wakeup_timer_active_flag && lfo_rise
      && (wakeup_prescale == rtwt_div_limit(wakeup_clock_select));
   wire wu_expire = wu_tick && (wakeup_count == `RTWT_RST_WORD) && !wu_gate;

   always @(posedge i_clk) begin
      if (i_rst) begin
         wakeup_timer_control <= 6'h00;
         wakeup_reload <= `RTWT_RST_WORD;
      end else if (wr_en) begin
         if (wr_index == `RTWT_IDX_WAKEUP_CONTROL) begin
            wakeup_timer_control <= wr_byte[5:0];
         end
         if (wr_index == `RTWT_IDX_WAKEUP_RELOAD) begin
            wakeup_reload <= i_hwdata[15:0];
         end
      end
   end

   always @(posedge i_clk) begin
      if (i_rst) begin
         wakeup_timer_active_flag <= 1'b0;
         wakeup_count <= `RTWT_RST_WORD;
         wakeup_prescale <= 5'h00;
         o_wakeup <= 1'b0;
         o_card_detect_start <= 1'b0;
         o_trim_start <= 1'b0;
      end else begin
         o_wakeup <= wu_expire && wakeup_on_expiry_enable;
         o_card_detect_start <= wu_expire && wakeup_auto_card_detect;
         o_trim_start <= wu_expire && wakeup_auto_oscillator_trim;
         if (wu_gate) begin
            wakeup_timer_active_flag <= wr_byte[`RTWT_WU_ACTIVE_BIT];
            if (wu_begin) begin
               wakeup_count <= wakeup_reload;
               wakeup_prescale <= 5'h00;
            end
         end else if (wu_expire) begin
            wakeup_prescale <= 5'h00;
            wakeup_count <= wakeup_reload;
            if (!wakeup_auto_reload && !wakeup_auto_card_detect) begin
               wakeup_timer_active_flag <= 1'b0;
            end
         end else if (wakeup_timer_active_flag && lfo_rise) begin
            if (wu_tick) begin
               wakeup_prescale <= 5'h00;
               wakeup_count <= wakeup_count - 16'h0001;
            end else begin
               wakeup_prescale <= wakeup_prescale + 5'h01;
            end
         end
      end
   end

endmodule // rtwt_timer

/* test/rtwt_timer_props.sv */
// Concurrent assertions on the timer block ports
`timescale 1ns/1ps
module rtwt_timer_props (
   input wire i_clk,
   input wire i_rst,
   input wire i_hsel,
   input wire [31:0] i_haddr,
   input wire [1:0] i_htrans,
   input wire i_hwrite,
   input wire [31:0] i_hwdata,
   input wire i_hready,
   input wire [31:0] o_hrdata,
   input wire i_first_underflow,
   input wire i_second_underflow,
   input wire i_tx_end,
   input wire o_timer3_underflow,
   input wire o_timer3_running,
   input wire o_wakeup,
   input wire o_card_detect_start
);
   // ****************
   // Bus snoop
   // ****************
   logic a_wr, a_rd;
   logic [7:0] a_idx, t3c, wuc;
   always @(posedge i_clk) begin
      a_idx <= i_haddr[9:2];
      if (i_rst) begin
         a_wr <= 1'b0;
         a_rd <= 1'b0;
         t3c <= 8'h00;
         wuc <= 8'h00;
      end else begin
         a_wr <= i_hsel && i_hready && i_htrans[1] && i_hwrite;
         a_rd <= i_hsel && i_hready && i_htrans[1] && !i_hwrite;
         if (a_wr && a_idx == 8'h1e) begin
            t3c <= i_hwdata[7:0];
         end
         if (a_wr && a_idx == 8'h23) begin
            wuc <= i_hwdata[7:0];
         end
      end
   end
   // ****************
   // Properties
   // ****************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   uf_running_a: assert property (o_timer3_underflow |-> $past(o_timer3_running))
      else $error("underflow while stopped");
   uf_first_a: assert property (o_timer3_underflow && t3c[1:0] == 2'h2 |->
      $past(i_first_underflow) || $past(i_first_underflow, 2)) else $error("bad first tick");
   uf_second_a: assert property (o_timer3_underflow && t3c[1:0] == 2'h3 |->
      $past(i_second_underflow) || $past(i_second_underflow, 2)) else $error("bad second tick");
   tx_start_a: assert property (i_tx_end && t3c[5:4] == 2'h1 |-> ##[1:2] o_timer3_running)
      else $error("no start at transmit end");
   wake_gate_a: assert property (o_wakeup |-> wuc[2])
      else $error("wake-up while disabled");
   card_gate_a: assert property (o_card_detect_start |-> wuc[4])
      else $error("card detect while disabled");
   wake_stop_a: assert property (a_wr && a_idx == 8'h23 && i_hwdata[7:6] == 2'h1 |->
      ##3 (!o_wakeup && !o_card_detect_start) [*8]) else $error("expiry after stop");
   gate_read_a: assert property (a_rd && a_idx == 8'h23 |-> !o_hrdata[6])
      else $error("write gate reads back");
endmodule // rtwt_timer_props

/* test/tb_rtwt_timer.sv */
// Self-checking testbench for the timer block
`timescale 1ns/1ps
module tb_rtwt_timer;
   logic clk = 0, rst = 1, hsel = 0, hwrite = 0, low_frequency_oscillator = 0;
   logic dtk = 0, fuf = 0, suf = 0, txe = 0, rx4 = 0;
   logic [31:0] haddr = 0, hwdata = 0, rv, c0;
   logic [1:0] htrans = 0;
   wire [31:0] hrdata;
   wire hready, wake, card, uf, trim;
   int err_total = 0, cmp_count = 0, wk_n = 0, cd_n = 0, n = 0, b = 0;
   int uf_n = 0, tm_n = 0;
   int dv[4] = '{1, 8, 16, 32};
   rtwt_timer dut_u (.i_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
      .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(),
      .i_derived_tick(dtk), .i_first_underflow(fuf), .i_second_underflow(suf),
      .i_tx_end(txe), .i_rx_four_bits(rx4), .i_lfo_clk(low_frequency_oscillator), .o_timer3_underflow(uf),
      .o_timer3_running(), .o_wakeup(wake), .o_card_detect_start(card), .o_trim_start(trim));
   initial begin
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      wk_n <= wk_n + (wake === 1'b1);
      cd_n <= cd_n + (card === 1'b1);
      uf_n <= uf_n + (uf === 1'b1);
      tm_n <= tm_n + (trim === 1'b1);
   end
   // ****************
   // Tasks
   // ****************
   task automatic end_of_test;
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_rdy;
      n = 0;
      @(posedge clk);
      while (hready !== 1'b1) begin
         n++;
         if (n > 50) begin
            err_total++;
            end_of_test;
         end
         @(posedge clk);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {22'h0, idx, 2'h0};
      hsel <= 1'b1;
      wait_rdy;
      htrans <= 2'h0;
      hwdata <= {24'h00_0000, wd};
      wait_rdy;
      rv = hrdata;
   endtask
   task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
      bus(1'b0, idx, 8'h00);
      chk(rv, {24'h00_0000, e});
   endtask
   task automatic rds(input logic [7:0] e);
      bus(1'b0, 8'h31, 8'h00);
      chk(rv & 32'h0000_0009, {24'h00_0000, e});
   endtask
   task automatic pls(input int s, input int k);
      repeat (k) begin
         {rx4, txe, suf, fuf, dtk} <= 5'h1 << s;
         @(posedge clk);
         {rx4, txe, suf, fuf, dtk} <= 5'h0;
         @(posedge clk);
      end
   endtask
   task automatic lfe(input int k);
      repeat (k) begin
         low_frequency_oscillator <= 1'b1;
         repeat (4) @(posedge clk);
         low_frequency_oscillator <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask
   // ****************
   // Tests
   // ****************
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rdc(8'h1f, 8'h00);
      bus(1, 8'h1f, 8'ha5);
      bus(1, 8'h20, 8'h3c);
      bus(1, 8'h21, 8'h77);
      bus(1, 8'h3f, 8'h55);
      rdc(8'h1f, 8'ha5);
      rdc(8'h20, 8'h3c);
      rdc(8'h21, 8'h00);
      rdc(8'h3f, 8'h00);
      rdc(8'h23, 8'h00);
      $display("registers done");
      bus(1, 8'h1e, 8'h00);
      bus(1, 8'h1f, 8'h00);
      bus(1, 8'h20, 8'h40);
      bus(1, 8'h31, 8'h02);
      bus(0, 8'h22, 8'h00);
      c0 = rv;
      bus(0, 8'h22, 8'h00);
      chk(c0 - rv, 32'h2);
      bus(1, 8'h31, 8'h04);
      bus(1, 8'h1e, 8'h02);
      bus(1, 8'h1f, 8'h01);
      bus(1, 8'h20, 8'h05);
      bus(1, 8'h31, 8'h02);
      rdc(8'h21, 8'h01);
      pls(1, 3);
      pls(2, 2);
      rdc(8'h22, 8'h02);
      bus(1, 8'h1f, 8'h00);
      bus(1, 8'h20, 8'h09);
      rdc(8'h21, 8'h01);
      bus(1, 8'h31, 8'h02);
      rdc(8'h22, 8'h09);
      pls(1, 9);
      rds(8'h08);
      pls(1, 1);
      rds(8'h01);
      bus(1, 8'h31, 8'h01);
      bus(1, 8'h1e, 8'h0b);
      bus(1, 8'h20, 8'h02);
      bus(1, 8'h31, 8'h02);
      pls(2, 3);
      rds(8'h09);
      rdc(8'h22, 8'h02);
      bus(1, 8'h31, 8'h05);
      bus(1, 8'h1e, 8'h01);
      bus(1, 8'h20, 8'h01);
      bus(1, 8'h31, 8'h02);
      repeat (6) @(posedge clk);
      rdc(8'h22, 8'h01);
      pls(0, 1);
      rdc(8'h22, 8'h00);
      bus(1, 8'h31, 8'h05);
      $display("counter done");
      bus(1, 8'h1f, 8'hff);
      for (int m = 0; m < 4; m++) begin
         bus(1, 8'h1e, {2'h2, m[1:0], 4'h0});
         pls(3, 1);
         rds((m == 1) ? 8'h08 : 8'h00);
         bus(1, 8'h31, 8'h02);
         pls(4, 1);
         rds((m > 1) ? 8'h08 : 8'h00);
         bus(1, 8'h31, 8'h04);
      end
      bus(1, 8'h1f, 8'h00);
      bus(1, 8'h20, 8'h03);
      for (int t = 2; t < 4; t++) begin
         b = uf_n;
         bus(1, 8'h1e, {2'h0, t[1:0], 4'h0});
         lfe(1);
         rds((t == 3) ? 8'h01 : 8'h00);
         chk(uf_n, b + ((t == 3) ? 1 : 0));
         bus(1, 8'h31, 8'h01);
      end
      bus(1, 8'h1e, 8'h00);
      $display("start modes done");
      bus(1, 8'h30, 8'h00);
      bus(1, 8'h23, 8'h80);
      rdc(8'h23, 8'h00);
      for (int c = 0; c < 4; c++) begin
         b = wk_n;
         bus(1, 8'h23, {6'h31, c[1:0]});
         rdc(8'h23, {6'h21, c[1:0]});
         lfe(dv[c] - 1);
         chk(wk_n, b);
         lfe(1);
         chk(wk_n, b + 1);
         rdc(8'h23, {6'h01, c[1:0]});
      end
      bus(1, 8'h23, 8'hf0);
      lfe(1);
      chk(cd_n, 1);
      chk(tm_n, 1);
      bus(1, 8'h23, 8'h10);
      rdc(8'h23, 8'h90);
      bus(1, 8'h23, 8'h50);
      rdc(8'h23, 8'h10);
      lfe(2);
      chk(cd_n, 1);
      chk(tm_n, 1);
      $display("wake-up done");
      end_of_test;
   end
endmodule // tb_rtwt_timer
bind rtwt_timer rtwt_timer_props chk_u (.i_clk(i_clk), .i_rst(i_rst), .i_hsel(i_hsel),
   .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata),
   .i_hready(i_hready), .o_hrdata(o_hrdata), .i_first_underflow(i_first_underflow),
   .i_second_underflow(i_second_underflow), .i_tx_end(i_tx_end),
   .o_timer3_underflow(o_timer3_underflow), .o_timer3_running(o_timer3_running),
   .o_wakeup(o_wakeup), .o_card_detect_start(o_card_detect_start));
